/* logic/sysal_bank.sv */
// Status register bank with set alias, alert mask and averaging pace
`timescale 1ns/1ps

//
// Contract
// RULE1 - Four-bit averaging code, default 0101
// RULE2 - Codes 1100..1111 average 8192..65536 samples
// RULE3 - Those averages last 2.32 to 18.6 s
// RULE4 - Alert flag bit 15 sets on alert
// RULE5 - Alert cleared by write or alert response
// RULE6 - Alert routable to GPIO, either polarity
// RULE7 - Latched alert bit 14, cleared by write only
// RULE8 - Latched alert routable to GPIO, either polarity
// RULE9 - Bit 11 one after power-on, zero after reboot
// RULE10 - Bit 10 latched after every reset
// RULE11 - Bit 7 set when average finishes
// RULE12 - Bit 6 set when both channels converted
// RULE13 - Bit 0 mirrors second status; mask read-only
// RULE14 - Reset values of status and mask
// RULE15 - Write one clears; alias write one sets
// RULE16 - Only unmasked newly set bits raise alert
module sysal_bank #(
    parameter int N_GPIO        = 3,
    parameter int SAMPLE_CYCLES = sysal_pkg::SAMPLE_CYCLES
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  srst_i,
    input  wire sysal_pkg::sysal_req_t req_i,
    input  wire logic                  reboot_cause_i,
    input  wire logic                  ara_done_i,
    input  wire logic                  cur_conv_done_i,
    input  wire logic                  volt_conv_done_i,
    input  wire logic                  status_two_any_i,
    input  wire logic [2*N_GPIO-1:0]   gpio_sel_i,
    input  wire logic [N_GPIO-1:0]     gpio_inv_i,
    output logic [15:0]                rdata_o,
    output logic                       rvalid_o,
    output logic [N_GPIO-1:0]          gpio_o,
    output logic [3:0]                 avg_code_o,
    output logic                       disp_avg_o,
    output logic                       avg_done_o
);

    // Samples per average for a code: two to the power code plus one
    function automatic logic [16:0] avg_samples(input logic [3:0] code);
        // Five-bit exponent so code 1111 does not wrap to zero
        avg_samples = 17'h00001 << ({1'b0, code} + 5'h01); // RULE2
    endfunction

    logic [15:0] status;
    logic [15:0] mask;
    logic [3:0]  avg_code;
    logic        disp_avg;
    logic        capture_pend;
    logic        cur_seen;
    logic        volt_seen;
    logic [16:0] pace_cnt;
    logic [16:0] sample_cnt;
    logic        avg_done;

    // Address decode of the command port
    wire hit_status = req_i.addr == sysal_pkg::STATUS_OFS;
    wire hit_setter = req_i.addr == sysal_pkg::SETTER_OFS;
    wire hit_mask   = req_i.addr == sysal_pkg::MASK_OFS;
    wire hit_avg    = req_i.addr == sysal_pkg::AVG_SEL_OFS;
    wire wr_status  = req_i.wr && hit_status;
    wire wr_setter  = req_i.wr && hit_setter;
    wire wr_mask    = req_i.wr && hit_mask;
    wire wr_avg     = req_i.wr && hit_avg;

    // Sample pace and average length
    wire        sample_tick = pace_cnt == 17'(SAMPLE_CYCLES - 1); // RULE3
    wire [16:0] avg_target  = avg_samples(avg_code);
    wire        avg_end     = sample_tick
                              && (sample_cnt >= avg_target - 17'h00001);

    // Full conversion once both channels have reported
    wire cur_now  = cur_seen || cur_conv_done_i;
    wire volt_now = volt_seen || volt_conv_done_i;
    wire conv_full = cur_now && volt_now; // RULE12

    // Hardware set sources
    wire [15:0] hw_set = {4'h0,
                          capture_pend && !reboot_cause_i, // RULE9
                          capture_pend,                    // RULE10
                          2'h0,
                          avg_done,                        // RULE11
                          conv_full,                       // RULE12
                          6'h00};
    wire [15:0] alias_set = wr_setter ? req_i.wdata & sysal_pkg::STATUS_IMPL
                                      : 16'h0000; // RULE15
    wire [15:0] w1c_clr   = wr_status ? req_i.wdata & sysal_pkg::STATUS_IMPL
                                      : 16'h0000; // RULE15
    wire        sum_rise  = status_two_any_i && !status[sysal_pkg::SUMMARY_BIT];

    // Alert when an unmasked bit becomes set
    wire [15:0] new_set   = (hw_set | alias_set
                             | {15'h0000, sum_rise})
                            & ~status & ~mask
                            & ~sysal_pkg::ALERT_BITS; // RULE16
    wire        alert_raise = |new_set; // RULE16

    // Next status; set beats clear on every flag
    wire [15:0] kept      = (status & ~w1c_clr) | hw_set | alias_set;
    wire        next_alert = (status[sysal_pkg::ALERT_BIT]
                              && !w1c_clr[sysal_pkg::ALERT_BIT]
                              && !ara_done_i) // RULE5
                             || alert_raise
                             || alias_set[sysal_pkg::ALERT_BIT]; // RULE4
    wire        next_lalert = (status[sysal_pkg::LALERT_BIT]
                               && !w1c_clr[sysal_pkg::LALERT_BIT])
                              || alert_raise
                              || alias_set[sysal_pkg::LALERT_BIT]; // RULE7
    wire [15:0] next_status = {next_alert, next_lalert,
                               kept[13:1] & sysal_pkg::STATUS_IMPL[13:1],
                               status_two_any_i}; // RULE13

    // Read data selection; unmapped reads return zero
    wire [15:0] avg_reg  = {8'h00, disp_avg, 3'h0, avg_code};
    wire [15:0] next_rd  = hit_status || hit_setter ? status
                         : hit_mask ? mask
                         : hit_avg  ? avg_reg
                         : 16'h0000;

    // GPIO routing: select 1 alert, 2 latched alert, else low
    logic [N_GPIO-1:0] next_gpio;
    always_comb begin
        for (int g = 0; g < N_GPIO; g++) begin
            case (gpio_sel_i[2*g +: 2])
                2'h1:    next_gpio[g] = status[sysal_pkg::ALERT_BIT]
                                        ^ gpio_inv_i[g]; // RULE6
                2'h2:    next_gpio[g] = status[sysal_pkg::LALERT_BIT]
                                        ^ gpio_inv_i[g]; // RULE8
                default: next_gpio[g] = 1'b0;
            endcase
        end
    end

    // Status, mask and averaging-select registers
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            status       <= sysal_pkg::STATUS_RST; // RULE14
            mask         <= sysal_pkg::MASK_RST;   // RULE14
            avg_code     <= sysal_pkg::AVG_CODE_RST; // RULE1
            disp_avg     <= sysal_pkg::DISP_AVG_RST;
            capture_pend <= 1'b1;
        end else begin
            status       <= next_status;
            capture_pend <= 1'b0;
            if (wr_mask) begin
                mask <= req_i.wdata & sysal_pkg::MASK_RW; // RULE13
            end
            if (wr_avg) begin
                avg_code <= req_i.wdata[3:0]; // RULE1
                disp_avg <= req_i.wdata[sysal_pkg::DISP_AVG_BIT];
            end
        end
    end

    // Conversion half-done tracking
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || conv_full) begin
            cur_seen  <= 1'b0;
            volt_seen <= 1'b0;
        end else begin
            cur_seen  <= cur_now;
            volt_seen <= volt_now;
        end
    end

    // Sample pace divider and sample counter
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || wr_avg) begin
            pace_cnt   <= 17'h00000;
            sample_cnt <= 17'h00000;
            avg_done   <= 1'b0;
        end else begin
            pace_cnt <= sample_tick ? 17'h00000 : pace_cnt + 17'h00001;
            avg_done <= avg_end; // RULE11
            if (avg_end) begin
                sample_cnt <= 17'h00000;
            end else if (sample_tick) begin
                sample_cnt <= sample_cnt + 17'h00001; // RULE2
            end
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdata_o    <= 16'h0000;
            rvalid_o   <= 1'b0;
            gpio_o     <= '0;
            avg_code_o <= sysal_pkg::AVG_CODE_RST;
            disp_avg_o <= sysal_pkg::DISP_AVG_RST;
            avg_done_o <= 1'b0;
        end else begin
            rdata_o    <= req_i.rd ? next_rd : 16'h0000;
            rvalid_o   <= req_i.rd;
            gpio_o     <= next_gpio; // RULE6
            avg_code_o <= avg_code;
            disp_avg_o <= disp_avg;
            avg_done_o <= avg_done;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_unmasked_set;
        alert_raise;
    endsequence
    sequence s_both_flags;
        status[sysal_pkg::ALERT_BIT] && status[sysal_pkg::LALERT_BIT];
    endsequence

    a_alert_on_set: assert property ( // RULE4
        s_unmasked_set |=> s_both_flags)
        else $error("alert not set after unmasked event");
    a_ara_clears: assert property ( // RULE5
        ara_done_i && !alert_raise && !alias_set[sysal_pkg::ALERT_BIT]
        |=> !status[sysal_pkg::ALERT_BIT])
        else $error("alert response did not clear alert");
    a_lalert_holds: assert property ( // RULE7
        status[sysal_pkg::LALERT_BIT] && !wr_status
        |=> status[sysal_pkg::LALERT_BIT])
        else $error("latched alert dropped without write");
    a_gpio_route: assert property ( // RULE6
        gpio_sel_i[1:0] == 2'h1 && $stable(gpio_sel_i) && $stable(gpio_inv_i)
        |=> gpio_o[0] == ($past(status[sysal_pkg::ALERT_BIT])
                          ^ gpio_inv_i[0]))
        else $error("gpio does not follow alert");
    a_cold_boot: assert property ( // RULE9
        $fell(capture_pend) |-> status[sysal_pkg::RESTART_BIT]
        && status[sysal_pkg::COLD_BIT] == !$past(reboot_cause_i))
        else $error("reset cause flags wrong");
    a_avg_done_set: assert property ( // RULE11
        avg_done |=> status[sysal_pkg::AVG_DONE_BIT])
        else $error("average done flag not set");
    a_conv_flag_set: assert property ( // RULE12
        cur_conv_done_i && volt_conv_done_i |=> status[sysal_pkg::CONV_BIT])
        else $error("conversion flag not set");
    a_summary_mirror: assert property ( // RULE13
        ##1 status[sysal_pkg::SUMMARY_BIT] == $past(status_two_any_i)
        && mask[sysal_pkg::SUMMARY_BIT] == 1'b0)
        else $error("summary bit does not mirror second status");
    a_w1c_clears: assert property ( // RULE15
        wr_status && req_i.wdata[sysal_pkg::CONV_BIT] && !conv_full
        && !alias_set[sysal_pkg::CONV_BIT]
        |=> !status[sysal_pkg::CONV_BIT])
        else $error("write one did not clear flag");
    a_masked_quiet: assert property ( // RULE16
        new_set == 16'h0000 && !alias_set[sysal_pkg::ALERT_BIT]
        && !status[sysal_pkg::ALERT_BIT]
        |=> !status[sysal_pkg::ALERT_BIT])
        else $error("alert raised without unmasked cause");
    a_avg_length: assert property ( // RULE2
        avg_end |-> sample_cnt == avg_target - 17'h00001)
        else $error("average ended at wrong sample count");

endmodule

/* inc/sysal_pkg.sv */
// Package: register map, field layout and timing for the status/alert bank
package sysal_pkg;

    // Register offsets (command codes)
    localparam logic [15:0] STATUS_OFS   = 16'h00E0;
    localparam logic [15:0] SETTER_OFS   = 16'hFECA;
    localparam logic [15:0] MASK_OFS     = 16'hFEDA;
    localparam logic [15:0] AVG_SEL_OFS  = 16'h00D9;

    // Status field positions
    localparam int ALERT_BIT     = 15;
    localparam int LALERT_BIT    = 14;
    localparam int COLD_BIT      = 11;
    localparam int RESTART_BIT   = 10;
    localparam int AVG_DONE_BIT  = 7;
    localparam int CONV_BIT      = 6;
    localparam int SUMMARY_BIT   = 0;

    // Implemented status bits, alert bits, writable mask bits
    localparam logic [15:0] STATUS_IMPL  = 16'hCCC1;
    localparam logic [15:0] ALERT_BITS   = 16'hC000;
    localparam logic [15:0] MASK_RW      = 16'h3CFE;

    // Reset values
    localparam logic [15:0] STATUS_RST   = 16'h0000;
    localparam logic [15:0] MASK_RST     = 16'h3CFE;

    // Averaging-select layout and reset
    localparam int          AVG_CODE_W   = 4;
    localparam int          DISP_AVG_BIT = 7;
    localparam logic [3:0]  AVG_CODE_RST = 4'h5;
    localparam logic        DISP_AVG_RST = 1'b1;

    // Timing: the 8192-sample entry (code 1100) gives the per-sample pace
    localparam longint CLK_PERIOD_NS   = 20;
    localparam longint AVG_TIME_TOP_NS = 64'd2320000000;
    localparam longint AVG_SAMPLES_TOP = 8192;
    localparam int     SAMPLE_CYCLES   = int'(AVG_TIME_TOP_NS
                                         / (CLK_PERIOD_NS * AVG_SAMPLES_TOP));
    localparam int     SAMPLE_CNT_W    = 17;

    // Register request from the serial command decoder
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } sysal_req_t;

endpackage

/* verification/sysal_host_model.sv */
// Host model issuing register reads and writes to the bank
`timescale 1ns/1ps
module sysal_host_model (
    input  wire logic             ref_clk_i,
    output sysal_pkg::sysal_req_t req_o,
    input  wire logic [15:0]      rdata_i,
    input  wire logic             rvalid_i
);
    initial req_o = '0;

    // Write: one-cycle strobe, held until the taking edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk_i);
        req_o <= '0;
    endtask

    // Read: answer taken at the edge after the strobe is taken
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge ref_clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge ref_clk_i);
        req_o <= '0;
        @(posedge ref_clk_i);
        d = rvalid_i ? rdata_i : 16'hXXXX; // Missing answer never matches
    endtask
endmodule

/* verification/tb_top.sv */
// Self-checking testbench for the status and alert bank
`timescale 1ns/1ps
module tb_top;
    localparam int         SC = 4;
    localparam int         AVG_N = 8192 * SC;
    logic                  clk = 1'b0;
    logic                  srst = 1'b1;
    sysal_pkg::sysal_req_t req;
    logic                  cause = 1'b0;
    logic                  ara = 1'b0;
    logic                  cur = 1'b0;
    logic                  volt = 1'b0;
    logic                  two = 1'b0;
    logic [15:0]           rdata;
    logic                  rvalid;
    logic [2:0]            gpio;
    logic [3:0]            code;
    logic                  disp;
    logic                  avg_done;
    logic [15:0]           v;
    int                    n_mismatch = 0;
    int                    n_checks = 0;
    int                    cyc;

    always #10 clk = ~clk;

    sysal_bank #(.N_GPIO(3), .SAMPLE_CYCLES(SC)) i_dut (
        .ref_clk_i(clk), .srst_i(srst), .req_i(req),
        .reboot_cause_i(cause), .ara_done_i(ara),
        .cur_conv_done_i(cur), .volt_conv_done_i(volt),
        .status_two_any_i(two), .gpio_sel_i(6'h09), .gpio_inv_i(3'h6),
        .rdata_o(rdata), .rvalid_o(rvalid), .gpio_o(gpio),
        .avg_code_o(code), .disp_avg_o(disp), .avg_done_o(avg_done));

    sysal_host_model i_host (
        .ref_clk_i(clk), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

    // Comparison with mismatch report
    task automatic chk(input string w, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", w, e, g);
        end
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
        i_host.rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask

    task automatic do_reset(input logic c);
        cause <= c;
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
    endtask

    // Two separate channel completions
    task automatic conv();
        @(posedge clk) cur <= 1'b1;
        @(posedge clk) cur <= 1'b0;
        @(posedge clk) volt <= 1'b1;
        @(posedge clk) volt <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        do_reset(1'b0);
        rdchk(sysal_pkg::STATUS_OFS, 16'h0C00);
        rdchk(sysal_pkg::SETTER_OFS, 16'h0C00);
        rdchk(sysal_pkg::MASK_OFS, 16'h3CFE);
        rdchk(sysal_pkg::AVG_SEL_OFS, 16'h0085);
        rdchk(16'h00E3, 16'h0000);
        i_host.wr(sysal_pkg::MASK_OFS, 16'hFFFF);
        rdchk(sysal_pkg::MASK_OFS, 16'h3CFE);
        i_host.wr(sysal_pkg::STATUS_OFS, 16'h0800);
        rdchk(sysal_pkg::STATUS_OFS, 16'h0400);
        i_host.wr(sysal_pkg::MASK_OFS, 16'h3CBE);
        conv();
        rdchk(sysal_pkg::STATUS_OFS, 16'hC440);
        chk("gpio", 16'h0001, {13'h0, gpio});
        @(posedge clk) ara <= 1'b1;
        @(posedge clk) ara <= 1'b0;
        rdchk(sysal_pkg::STATUS_OFS, 16'h4440);
        chk("gpio", 16'h0000, {13'h0, gpio});
        i_host.wr(sysal_pkg::STATUS_OFS, 16'h4040);
        rdchk(sysal_pkg::STATUS_OFS, 16'h0400);
        chk("gpio", 16'h0002, {13'h0, gpio});
        i_host.wr(sysal_pkg::MASK_OFS, 16'h3CFE);
        conv();
        rdchk(sysal_pkg::STATUS_OFS, 16'h0440);
        i_host.wr(sysal_pkg::SETTER_OFS, 16'h0080);
        i_host.wr(sysal_pkg::STATUS_OFS, 16'h0000);
        rdchk(sysal_pkg::STATUS_OFS, 16'h04C0);
        @(posedge clk) two <= 1'b1;
        i_host.wr(sysal_pkg::STATUS_OFS, 16'h0001);
        rdchk(sysal_pkg::STATUS_OFS, 16'hC4C1);
        @(posedge clk) two <= 1'b0;
        i_host.wr(sysal_pkg::STATUS_OFS, 16'hFFFF);
        rdchk(sysal_pkg::STATUS_OFS, 16'h0000);
        // Shortest long average, code 1100
        i_host.wr(sysal_pkg::AVG_SEL_OFS, 16'h000C);
        cyc = 0;
        while (avg_done !== 1'b1 && cyc < 40000) begin
            @(posedge clk);
            #1;
            cyc++;
        end
        chk("avg len", 16'h0001, 16'(cyc >= AVG_N && cyc <= AVG_N + 3));
        chk("code", 16'h000C, {11'h0, disp, code});
        rdchk(sysal_pkg::STATUS_OFS, 16'h0080);
        // Both channels finishing in the same cycle
        @(posedge clk) begin
            cur  <= 1'b1;
            volt <= 1'b1;
        end
        @(posedge clk) begin
            cur  <= 1'b0;
            volt <= 1'b0;
        end
        rdchk(sysal_pkg::STATUS_OFS, 16'h00C0);
        do_reset(1'b1);
        rdchk(sysal_pkg::STATUS_OFS, 16'h0400);
        rdchk(sysal_pkg::AVG_SEL_OFS, 16'h0085);
        report_and_stop();
    end
endmodule
